// File: rtl/uart_shadow_map.vh
// Address map, field positions, reset values and sizes of the shadow data buffer.
// Assumes byte addresses on a 32-bit register port, one aligned word per register.
`ifndef UART_SHADOW_MAP_VH
`define UART_SHADOW_MAP_VH

// ============================================================
// Addresses
`define SHADOW_FIRST_ADDR      32'h5000_1130
`define SHADOW_LAST_ADDR       32'h5000_116C
`define SHADOW_12_ADDR         32'h5000_1160
`define SHADOW_13_ADDR         32'h5000_1164
`define CTRL_ADDR              32'h5000_1100
`define LINE_STATUS_ADDR       32'h5000_1104
`define INT_STATUS_ADDR        32'h5000_1108
`define INT_MASK_ADDR          32'h5000_110C

// ============================================================
// Fields
`define CTRL_FIFO_EN_BIT       0
`define CTRL_IR_MODE_BIT       1
`define LSR_DR_BIT             0
`define LSR_OVERRUN_BIT        1
`define LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT           5
`define INT_RX_BIT             0
`define INT_OVERRUN_BIT        1
`define INT_TRANSMIT_HOLDING_EMPTY_FLAG_BIT           2
`define INT_TX_LOST_BIT        3
`define INT_WIDTH              4

// ============================================================
// Reset values and sizes
`define CTRL_RESET             2'h0
`define INT_MASK_RESET         4'h0
`define SHADOW_RESET           8'h00
`define FIFO_DEPTH             5'h10
`define FIFO_PTR_W             4
`define FIFO_CNT_W             5

`endif

// File: rtl/uart_shadow_data_buffer.v
// Shadow data buffer of a serial port: receive and transmit FIFOs or single holders.
// Assumes framers outside deliver received bytes as one-cycle pulses and take
// transmit bytes with a one-cycle take pulse; all inputs are synchronous to clk.
//
// How it works
// [R1] Sixteen aligned words all alias one buffer
// [R2] Read returns received byte in bits 7:0
// [R3] Reader trusts data only while ready flag set
// [R4] No FIFO: new byte overwrites, flags overrun if old one unread
// [R5] FIFO on: read returns receive FIFO head
// [R6] Full receive FIFO: drop newcomer, flag overrun
// [R7] Write queues byte to serial or infrared
// [R8] Writer writes only while holding empty set
// [R9] No FIFO: one write clears holding empty
// [R10] No FIFO: later writes replace pending byte
// [R11] FIFO on: sixteen writes fill transmit FIFO
// [R12] Write into full transmit FIFO is dropped
// [R13] Every alias has identical side effects
`timescale 1ns/1ps
`include "uart_shadow_map.vh"

module uart_shadow_data_buffer (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Register port
    input  wire [31:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Receive framers
    input  wire        rx_uart_valid,
    input  wire [7:0]  rx_uart_byte,
    input  wire        rx_ir_valid,
    input  wire [7:0]  rx_ir_byte,
    // Transmit framers
    input  wire        tx_take,
    output reg  [7:0]  tx_byte,
    output reg         tx_uart_req,
    output reg         tx_ir_req,
    // Interrupt
    output reg         irq
);

    // ============================================================
    // Decode
    function is_shadow;
        input [31:0] a;
        begin
            is_shadow = (a >= `SHADOW_FIRST_ADDR) && (a <= `SHADOW_LAST_ADDR)
                        && (a[1:0] == 2'h0);
        end
    endfunction

    function [`FIFO_PTR_W-1:0] ptr_inc;
        input [`FIFO_PTR_W-1:0] p;
        begin
            ptr_inc = p + {{(`FIFO_PTR_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // ============================================================
    // State
    // Receive storage, pointers and fill count
    reg  [7:0]             rx_mem [0:15];
    reg  [`FIFO_PTR_W-1:0] rx_rd_q;
    reg  [`FIFO_PTR_W-1:0] rx_rd_d;
    reg  [`FIFO_PTR_W-1:0] rx_wr_q;
    reg  [`FIFO_PTR_W-1:0] rx_wr_d;
    reg  [`FIFO_CNT_W-1:0] rx_cnt_q;
    reg  [`FIFO_CNT_W-1:0] rx_cnt_d;
    reg  [7:0]             rx_hold_q;

    // Transmit storage, pointers and fill count
    reg  [7:0]             tx_mem [0:15];
    reg  [`FIFO_PTR_W-1:0] tx_rd_q;
    reg  [`FIFO_PTR_W-1:0] tx_rd_d;
    reg  [`FIFO_PTR_W-1:0] tx_wr_q;
    reg  [`FIFO_PTR_W-1:0] tx_wr_d;
    reg  [`FIFO_CNT_W-1:0] tx_cnt_q;
    reg  [`FIFO_CNT_W-1:0] tx_cnt_d;
    reg  [7:0]             tx_hold_q;
    reg  [7:0]             tx_head_d;

    // Control and status
    reg  [1:0]             ctrl_q;
    reg  [1:0]             ctrl_d;
    reg                    overrun_q;
    reg                    overrun_d;
    reg                    transmit_holding_empty_flag_q;
    reg                    transmit_holding_empty_flag_d;
    reg  [`INT_WIDTH-1:0]  int_stat_q;
    reg  [`INT_WIDTH-1:0]  int_stat_d;
    reg  [`INT_WIDTH-1:0]  int_mask_q;
    reg  [`INT_WIDTH-1:0]  int_mask_d;
    reg  [`INT_WIDTH-1:0]  int_set;
    reg  [31:0]            rd_word;

    // Per-cycle events
    reg                    rx_pop;
    reg                    rx_push;
    reg                    tx_pop;
    reg                    tx_push;
    reg                    overrun_ev;
    reg                    tx_lost;

    // ============================================================
    // Mode and address decode
    wire       fifo_en  = ctrl_q[`CTRL_FIFO_EN_BIT];
    wire       ir_mode  = ctrl_q[`CTRL_IR_MODE_BIT];
    wire       sh_rd    = reg_rd & is_shadow(reg_addr); // R13
    wire       sh_wr    = reg_wr & is_shadow(reg_addr); // R1
    wire       ctrl_wr  = reg_wr & (reg_addr == `CTRL_ADDR);
    wire       ls_rd    = reg_rd & (reg_addr == `LINE_STATUS_ADDR);
    wire       stat_wr  = reg_wr & (reg_addr == `INT_STATUS_ADDR);
    wire       mask_wr  = reg_wr & (reg_addr == `INT_MASK_ADDR);
    // A FIFO enable change empties both paths so stale bytes never cross FIFO modes; an infrared mode change flushes nothing
    wire       flush    = ctrl_wr & (reg_wdata[`CTRL_FIFO_EN_BIT] != fifo_en);
    wire       rx_valid = ir_mode ? rx_ir_valid : rx_uart_valid; // R2
    wire [7:0] rx_byte  = ir_mode ? rx_ir_byte : rx_uart_byte;
    wire       dr       = (rx_cnt_q != {`FIFO_CNT_W{1'b0}});
    wire       transmit_holding_empty_flag     = (tx_cnt_q == {`FIFO_CNT_W{1'b0}});
    wire [7:0] rx_head  = fifo_en ? rx_mem[rx_rd_q] : rx_hold_q; // R5

    // Register images as software sees them; reserved bits read zero
    wire [31:0] ctrl_word     = {30'h0000_0000, ctrl_q};
    wire [31:0] line_word     = {26'h000_0000, transmit_holding_empty_flag, 3'h0, overrun_q, dr}; // R8
    wire [31:0] int_stat_word = {28'h000_0000, int_stat_q};
    wire [31:0] int_mask_word = {28'h000_0000, int_mask_q};

    // ============================================================
    // Counting
    // Fill count after at most one push and one pop in the same cycle;
    // the two may cancel, which keeps a full FIFO full under a read.
    function [`FIFO_CNT_W-1:0] cnt_next;
        input [`FIFO_CNT_W-1:0] c;
        input                   push;
        input                   pop;
        begin
            cnt_next = c + {{(`FIFO_CNT_W-1){1'b0}}, push}
                         - {{(`FIFO_CNT_W-1){1'b0}}, pop};
        end
    endfunction

    // ============================================================
    // Receive path
    // In FIFO mode a full queue keeps its contents and the newcomer is
    // dropped; without FIFOs the single holder takes the newest except during a FIFO enable change.
    always @* begin
        rx_pop  = sh_rd & dr;
        rx_rd_d = rx_rd_q;
        rx_wr_d = rx_wr_q;
        if (fifo_en) begin
            // A read in the same cycle frees the slot for the newcomer
            rx_push    = rx_valid & ((rx_cnt_q != `FIFO_DEPTH) | rx_pop);
            overrun_ev = rx_valid & ~rx_push; // R6
            if (rx_pop)
                rx_rd_d = ptr_inc(rx_rd_q);
            if (rx_push)
                rx_wr_d = ptr_inc(rx_wr_q);
            rx_cnt_d   = cnt_next(rx_cnt_q, rx_push, rx_pop);
        end else begin
            // A read in the same cycle takes the old byte, so no overrun
            rx_push    = rx_valid;
            overrun_ev = rx_valid & dr & ~sh_rd; // R4
            rx_cnt_d   = (rx_valid | (dr & ~sh_rd)) ? 5'h01 : 5'h00;
        end
        if (flush) begin
            // A byte arriving during the mode change is lost, flagging overrun only where it would have overrun anyway
            rx_push  = 1'b0;
            rx_rd_d  = {`FIFO_PTR_W{1'b0}};
            rx_wr_d  = {`FIFO_PTR_W{1'b0}};
            rx_cnt_d = {`FIFO_CNT_W{1'b0}};
        end
    end

    // ============================================================
    // Transmit path
    // The framer sees the head byte one cycle after any change, so the
    // next head is worked out here from the next pointers.
    always @* begin
        tx_pop  = tx_take & ~transmit_holding_empty_flag;
        tx_rd_d = tx_rd_q;
        tx_wr_d = tx_wr_q;
        tx_lost = 1'b0;
        if (fifo_en) begin
            // A take in the same cycle frees the slot for the write
            tx_push  = sh_wr & ((tx_cnt_q != `FIFO_DEPTH) | tx_pop); // R11
            tx_lost  = sh_wr & ~tx_push; // R12
            if (tx_pop)
                tx_rd_d = ptr_inc(tx_rd_q);
            if (tx_push)
                tx_wr_d = ptr_inc(tx_wr_q); // R7
            tx_cnt_d = cnt_next(tx_cnt_q, tx_push, tx_pop);
        end else begin
            // A write over a pending byte replaces it, never queues
            tx_push  = sh_wr; // R10
            tx_cnt_d = sh_wr ? 5'h01 : (tx_pop ? 5'h00 : tx_cnt_q); // R9
        end
        if (flush) begin
            tx_rd_d  = {`FIFO_PTR_W{1'b0}};
            tx_wr_d  = {`FIFO_PTR_W{1'b0}};
            tx_cnt_d = {`FIFO_CNT_W{1'b0}};
        end
        transmit_holding_empty_flag_d = (tx_cnt_d == {`FIFO_CNT_W{1'b0}});
        // Bypass a write that lands in the slot the framer reads next
        if (fifo_en)
            tx_head_d = (tx_push && tx_wr_q == tx_rd_d) ? reg_wdata[7:0] : tx_mem[tx_rd_d];
        else
            tx_head_d = sh_wr ? reg_wdata[7:0] : tx_hold_q;
    end

    // ============================================================
    // Control and line status
    always @* begin
        ctrl_d    = ctrl_wr ? reg_wdata[1:0] : ctrl_q;
        // Overrun clears on a status read, but a fresh overrun wins
        overrun_d = overrun_q;
        if (ls_rd)
            overrun_d = 1'b0;
        if (overrun_ev)
            overrun_d = 1'b1;
    end

    // ============================================================
    // Interrupts
    // Each event sets its sticky bit; a write of one clears it, and a
    // set in the same cycle wins so no event is ever lost.
    always @* begin
        int_set                   = {`INT_WIDTH{1'b0}};
        int_set[`INT_RX_BIT]      = rx_push;
        int_set[`INT_OVERRUN_BIT] = overrun_ev;
        int_set[`INT_TRANSMIT_HOLDING_EMPTY_FLAG_BIT]    = transmit_holding_empty_flag_d & ~transmit_holding_empty_flag_q;
        int_set[`INT_TX_LOST_BIT] = tx_lost;
    end

    always @* begin
        int_mask_d = mask_wr ? reg_wdata[3:0] : int_mask_q;
        int_stat_d = int_stat_q;
        if (stat_wr)
            int_stat_d = int_stat_q & ~reg_wdata[3:0];
        int_stat_d = int_stat_d | int_set;
    end

    // ============================================================
    // Read decode
    // Unmapped holes read as zero rather than as an alias
    always @* begin
        rd_word = 32'h0000_0000;
        if (is_shadow(reg_addr)) begin
            rd_word = {24'h00_0000, rx_head}; // R2
        end else begin
            case (reg_addr)
                `CTRL_ADDR:        rd_word = ctrl_word;
                `LINE_STATUS_ADDR: rd_word = line_word;
                `INT_STATUS_ADDR:  rd_word = int_stat_word;
                `INT_MASK_ADDR:    rd_word = int_mask_word;
                default:           rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // Storage
    // The arrays carry no reset: reads and tx_byte can show an unwritten slot while the count is zero
    always @(posedge clk) begin
        if (fifo_en && rx_push)
            rx_mem[rx_wr_q] <= rx_byte;
        if (fifo_en && tx_push)
            tx_mem[tx_wr_q] <= reg_wdata[7:0];
    end

    // ============================================================
    // Receive registers
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_rd_q   <= {`FIFO_PTR_W{1'b0}};
            rx_wr_q   <= {`FIFO_PTR_W{1'b0}};
            rx_cnt_q  <= {`FIFO_CNT_W{1'b0}};
            rx_hold_q <= `SHADOW_RESET;
        end else begin
            rx_rd_q  <= rx_rd_d;
            rx_wr_q  <= rx_wr_d;
            rx_cnt_q <= rx_cnt_d;
            if (!fifo_en && rx_push)
                rx_hold_q <= rx_byte; // R4
        end
    end

    // ============================================================
    // Transmit registers
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_rd_q   <= {`FIFO_PTR_W{1'b0}};
            tx_wr_q   <= {`FIFO_PTR_W{1'b0}};
            tx_cnt_q  <= {`FIFO_CNT_W{1'b0}};
            tx_hold_q <= `SHADOW_RESET;
            transmit_holding_empty_flag_q    <= 1'b1;
        end else begin
            tx_rd_q  <= tx_rd_d;
            tx_wr_q  <= tx_wr_d;
            tx_cnt_q <= tx_cnt_d;
            transmit_holding_empty_flag_q   <= transmit_holding_empty_flag_d;
            if (!fifo_en && sh_wr)
                tx_hold_q <= reg_wdata[7:0]; // R10
        end
    end

    // ============================================================
    // Control and status registers
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q     <= `CTRL_RESET;
            overrun_q  <= 1'b0;
            int_stat_q <= {`INT_WIDTH{1'b0}};
            int_mask_q <= `INT_MASK_RESET;
        end else begin
            ctrl_q     <= ctrl_d;
            overrun_q  <= overrun_d;
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
        end
    end

    // ============================================================
    // Outputs, each straight from a flip-flop
    // Request lines follow the next state so a take never sees a stale byte
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_byte     <= `SHADOW_RESET;
            tx_uart_req <= 1'b0;
            tx_ir_req   <= 1'b0;
        end else begin
            tx_byte     <= tx_head_d;
            tx_uart_req <= ~transmit_holding_empty_flag_d & ~ctrl_d[`CTRL_IR_MODE_BIT]; // R7
            tx_ir_req   <= ~transmit_holding_empty_flag_d & ctrl_d[`CTRL_IR_MODE_BIT]; // R7
        end
    end

    // Interrupt follows the next status so it rises with the event
    always @(posedge clk) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(int_stat_d & int_mask_d);
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge clk) begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rd_word;
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule // uart_shadow_data_buffer

// File: verification/shadow_monitor.sv
// Port checker for the shadow data buffer.
// Assumes it is bound to uart_shadow_data_buffer and sees only its ports.
`timescale 1ns/1ps
`include "uart_shadow_map.vh"
module shadow_monitor (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Register port
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Transmit side
    input wire        tx_take,
    input wire [7:0]  tx_byte,
    input wire        tx_uart_req,
    input wire        tx_ir_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire shadow = reg_addr >= `SHADOW_FIRST_ADDR && reg_addr <= `SHADOW_LAST_ADDR
                  && reg_addr[1:0] == 2'h0;
    // Gap between the control words and the first alias holds nothing
    wire hole = reg_addr[31:8] == 24'h50_0011 && reg_addr[7:0] > 8'h0C
                && reg_addr[7:0] < 8'h30;
    wire req = tx_uart_req | tx_ir_req;
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data seen without a read");
    a_rdata_upper: assert property (reg_rd && shadow |=> reg_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (reg_rd && hole |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_req_onehot: assert property (!(tx_uart_req && tx_ir_req))
        else $error("both transmit requests high");
    a_write_queues: assert property (reg_wr && shadow |=> req)
        else $error("shadow write left nothing pending");
    a_first_byte_out: assert property (reg_wr && shadow && !req
        |=> tx_byte == $past(reg_wdata[7:0]))
        else $error("written byte not presented");
    a_pending_holds: assert property (req && !tx_take && !reg_wr
        |=> $stable({tx_uart_req, tx_ir_req, tx_byte}))
        else $error("pending byte changed untouched");
    a_take_idle: assert property (tx_take && !req && !reg_wr |=> !req)
        else $error("take without request had effect");
endmodule // shadow_monitor

bind uart_shadow_data_buffer shadow_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_take(tx_take), .tx_byte(tx_byte),
    .tx_uart_req(tx_uart_req), .tx_ir_req(tx_ir_req));

// File: verification/framer_model.sv
// Far-side framers: deliver received bytes and take transmit bytes.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
module framer_model (
    // Clock
    input wire       clk,
    // Receive framers
    output reg       rx_uart_valid,
    output reg [7:0] rx_uart_byte,
    output reg       rx_ir_valid,
    output reg [7:0] rx_ir_byte,
    // Transmit framers
    output reg       tx_take
);
    initial begin
        {rx_uart_valid, rx_ir_valid, tx_take} = 3'h0;
        {rx_uart_byte, rx_ir_byte} = 16'h0000;
    end
    task send(input bit ir, input logic [7:0] b);
        @(posedge clk);
        rx_uart_valid <= !ir;
        rx_ir_valid   <= ir;
        {rx_uart_byte, rx_ir_byte} <= {b, b};
        @(posedge clk);
        {rx_uart_valid, rx_ir_valid} <= 2'h0;
        // Released data lines must not keep the byte
        {rx_uart_byte, rx_ir_byte} <= {~b, ~b};
    endtask
    task take;
        @(posedge clk);
        tx_take <= 1'b1;
        @(posedge clk);
        tx_take <= 1'b0;
    endtask
endmodule // framer_model

// File: verification/uart_shadow_data_buffer_test.sv
// Self-checking bench of the shadow data buffer over its register port.
// Assumes framer_model on the far side and shadow_monitor bound in.
`timescale 1ns/1ps
`include "uart_shadow_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module uart_shadow_data_buffer_test;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_take, tx_uart_req, tx_ir_req, irq;
    logic [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, reg_rdata;
    logic rx_uart_valid, rx_ir_valid;
    logic [7:0] rx_uart_byte, rx_ir_byte, tx_byte;
    int n_errors = 0, cmp_count = 0, i;
    always #2.5 clk = ~clk;
    uart_shadow_data_buffer u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_uart_valid(rx_uart_valid), .rx_uart_byte(rx_uart_byte),
        .rx_ir_valid(rx_ir_valid), .rx_ir_byte(rx_ir_byte), .tx_take(tx_take),
        .tx_byte(tx_byte), .tx_uart_req(tx_uart_req), .tx_ir_req(tx_ir_req), .irq(irq));
    framer_model u_peer (.clk(clk), .rx_uart_valid(rx_uart_valid),
        .rx_uart_byte(rx_uart_byte), .rx_ir_valid(rx_ir_valid),
        .rx_ir_byte(rx_ir_byte), .tx_take(tx_take));
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish;
    end
    // ============================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(`LINE_STATUS_ADDR, 32'h0000_0020);
        rd(`CTRL_ADDR, 32'h0000_0000);
        rd(`INT_MASK_ADDR, 32'h0000_0000);
        rd(32'h5000_1110, 32'h0000_0000);
        wr(`INT_MASK_ADDR, 32'h0000_0001);
        u_peer.send(0, 8'hA5);
        #1;
        `CHK(irq, 1'b1)
        rd(`LINE_STATUS_ADDR, 32'h0000_0021);
        rd(`SHADOW_12_ADDR, 32'h0000_00A5);
        rd(`LINE_STATUS_ADDR, 32'h0000_0020);
        wr(`INT_STATUS_ADDR, 32'h0000_0001);
        `CHK(irq, 1'b0)
        wr(`INT_MASK_ADDR, 32'h0000_0000);
        u_peer.send(0, 8'h01);
        u_peer.send(0, 8'h02);
        rd(`LINE_STATUS_ADDR, 32'h0000_0023);
        rd(`SHADOW_13_ADDR, 32'h0000_0002);
        `CHK(irq, 1'b0)
        rd(`INT_STATUS_ADDR, 32'h0000_0003);
        wr(`INT_STATUS_ADDR, 32'h0000_000F);
        // Infrared mode, no FIFOs
        wr(`CTRL_ADDR, 32'h0000_0002);
        u_peer.send(1, 8'h3C);
        rd(`SHADOW_12_ADDR, 32'h0000_003C);
        wr(`SHADOW_13_ADDR, 32'h0000_005A);
        `CHK({tx_ir_req, tx_uart_req, tx_byte}, 10'h25A)
        wr(`SHADOW_12_ADDR, 32'h0000_006B);
        `CHK(tx_byte, 8'h6B)
        rd(`LINE_STATUS_ADDR, 32'h0000_0000);
        u_peer.take;
        #1;
        `CHK(tx_ir_req, 1'b0)
        rd(`INT_STATUS_ADDR, 32'h0000_0005);
        wr(`INT_STATUS_ADDR, 32'h0000_000F);
        // FIFO mode: overfill receive, drain through every alias
        wr(`CTRL_ADDR, 32'h0000_0001);
        for (i = 0; i < 17; i++) u_peer.send(0, 8'(i));
        rd(`LINE_STATUS_ADDR, 32'h0000_0023);
        for (i = 0; i < 16; i++) rd(`SHADOW_FIRST_ADDR + 32'(4 * i), 32'(i));
        rd(`LINE_STATUS_ADDR, 32'h0000_0020);
        for (i = 0; i < 17; i++) wr(`SHADOW_FIRST_ADDR + 32'(4 * (i % 16)), 32'(64 + i));
        rd(`INT_STATUS_ADDR, 32'h0000_000B);
        for (i = 0; i < 16; i++) begin
            `CHK({tx_uart_req, tx_byte}, {1'b1, 8'(64 + i)})
            u_peer.take;
            #1;
        end
        `CHK(tx_uart_req, 1'b0)
        rd(`LINE_STATUS_ADDR, 32'h0000_0020);
        tally_and_finish;
    end
endmodule // uart_shadow_data_buffer_test
